/* File: pmcr_pkg.sv */
// Package of offsets, fields, reset values and timing for the power control registers
package pmcr_pkg;
	localparam logic [7:0] PMCR_IO_OFFSET = 8'h20;
	localparam logic [7:0] PMCR_IO_LIMIT = 8'h3f;
	localparam logic [7:0] PMCR_SLEEP_MODE_CONTROL_ADDR = 8'h53;
	localparam logic [7:0] PMCR_CPU_CONTROL_ADDR = 8'h55;
	localparam logic [7:0] PMCR_PERIPHERAL_CLOCK_GATE_ADDR = 8'h64;
	localparam logic [7:0] PMCR_SLEEP_MODE_CONTROL_RESET = 8'h00;
	localparam logic [7:0] PMCR_CPU_CONTROL_RESET = 8'h00;
	localparam logic [7:0] PMCR_PERIPHERAL_CLOCK_GATE_RESET = 8'h00;
	localparam logic [7:0] PMCR_SLEEP_MODE_CONTROL_MASK = 8'h0f;
	localparam logic [7:0] PMCR_CPU_CONTROL_MASK = 8'hf3;
	localparam int PMCR_SLEEP_ARM_BIT = 0;
	localparam int PMCR_SLEEP_MODE_LO_BIT = 1;
	localparam int PMCR_SLEEP_MODE_HI_BIT = 3;
	localparam int PMCR_SCAN_PORT_OFF_BIT = 7;
	localparam int PMCR_BROWNOUT_SLEEP_OFF_BIT = 6;
	localparam int PMCR_BROWNOUT_SLEEP_UNLOCK_BIT = 5;
	localparam int PMCR_PULLUP_GLOBAL_OFF_BIT = 4;
	localparam int PMCR_VECTOR_BASE_SELECT_BIT = 1;
	localparam int PMCR_VECTOR_CHANGE_UNLOCK_BIT = 0;
	localparam int PMCR_GATE_TWO_WIRE_BIT = 7;
	localparam int PMCR_GATE_TIMER_TWO_BIT = 6;
	localparam int PMCR_GATE_TIMER_ZERO_BIT = 5;
	localparam int PMCR_GATE_SERIAL_ONE_BIT = 4;
	localparam int PMCR_GATE_TIMER_ONE_BIT = 3;
	localparam int PMCR_GATE_SPI_PORT_BIT = 2;
	localparam int PMCR_GATE_SERIAL_ZERO_BIT = 1;
	localparam int PMCR_GATE_CONVERTER_BIT = 0;
	localparam logic [2:0] PMCR_TIMED_WINDOW_CYCLES = 3'h4;
	localparam logic [2:0] PMCR_BROWNOUT_DELAY_CYCLES = 3'h3;
	localparam logic [2:0] PMCR_BROWNOUT_ACTIVE_CYCLES = 3'h3;
	localparam logic [2:0] PMCR_STANDBY_WAKE_CYCLES = 3'h6;
	typedef enum logic [2:0]
	{
		PMCR_MODE_IDLE = 3'h0,
		PMCR_MODE_NOISE_REDUCTION = 3'h1,
		PMCR_MODE_POWER_DOWN = 3'h2,
		PMCR_MODE_POWER_SAVE = 3'h3,
		PMCR_MODE_STANDBY = 3'h6,
		PMCR_MODE_EXT_STANDBY = 3'h7
	} pmcr_sleep_mode_t;
endpackage

/* File: pmcr_power_control.sv */
// Power management and system control register block
// Behaviour
// RULE1: Registers decode at data address and at address minus 0x20 below 0x40.
// RULE2: Sleep mode field bits 3:1 chooses idle, noise, down, save, standby modes.
// RULE3: Sleep instruction causes sleep only while sleep arm bit is one.
// RULE4: Software sets sleep arm just before sleeping and clears it after waking.
// RULE5: Scan port off bit zero enables scan port if fuse programmed; one disables.
// RULE6: Scan port off changes only on two equal writes within four cycles.
// RULE7: Software leaves scan port off alone while on-chip debug runs.
// RULE8: Brownout sleep off sets only by unlock write then set write within four.
// RULE9: Brownout sleep off active three cycles after set, clears three later.
// RULE10: Global pull-up off forces every port pull-up off.
// RULE11: Vector base select chooses flash start or boot section start.
// RULE12: Vector base select changes only after unlock write, within four cycles.
// RULE13: Vector unlock clears after four cycles or when select is written.
// RULE14: Interrupts masked from unlock until after next instruction, or four cycles.
// RULE15: Section lock bits block interrupts while running the other section.
// RULE16: Clock gate bits stop the clock of their peripherals.
// RULE17: Timer two gate acts only when timer two runs synchronously.
// RULE18: Ungated timers resume from saved state; others need software reinit.
// RULE19: Converter gated blocks comparator use of converter multiplexer.
// RULE20: Software avoids gating the SPI port while single-wire debug runs.
// RULE21: Gated peripheral state frozen and its registers inaccessible.
// RULE22: Wake from standby modes completes six cycles after wake condition.
// RULE23: Unused sleep and cpu control bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module pmcr_power_control
	import pmcr_pkg::*;
#(
	parameter int GATE_COUNT = 8
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// CPU register access
	input wire logic [7:0] addr_i,
	input wire logic io_space_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	output logic hit_o,
	// Sleep control
	input wire logic sleep_instr_i,
	input wire logic wake_i,
	output logic sleep_o,
	output logic [2:0] sleep_mode_o,
	output logic wake_ready_o,
	output logic brownout_off_o,
	// Fuses and locks
	input wire logic scan_port_fuse_i,
	input wire logic app_lock_bit_i,
	input wire logic boot_lock_bit_i,
	input wire logic exec_in_boot_i,
	input wire logic timer_two_async_select_i,
	// System controls
	output logic scan_port_enable_o,
	output logic pullup_global_off_o,
	output logic vector_base_select_o,
	output logic irq_block_o,
	output logic [GATE_COUNT-1:0] gate_clock_o,
	output logic [GATE_COUNT-1:0] periph_access_ok_o,
	output logic comparator_mux_allow_o
);
	logic [3:0] sleep_mode_control_reg, sleep_mode_control_next;
	logic scan_off_reg, scan_off_next;
	logic scan_pend_reg, scan_pend_next;
	logic scan_val_reg, scan_val_next;
	logic [2:0] scan_cnt_reg, scan_cnt_next;
	logic brownout_sleep_off_reg, brownout_sleep_off_next;
	logic brownout_sleep_unlock_reg, brownout_sleep_unlock_next;
	logic [2:0] brownout_sleep_unlock_cnt_reg, brownout_sleep_unlock_cnt_next;
	logic [2:0] brownout_sleep_off_cnt_reg, brownout_sleep_off_cnt_next;
	logic pud_reg, pud_next;
	logic vector_base_select_reg, vector_base_select_next;
	logic vector_change_unlock_reg, vector_change_unlock_next;
	logic [2:0] vector_change_unlock_cnt_reg, vector_change_unlock_cnt_next;
	logic ivmask_tail_reg, ivmask_tail_next;
	logic [7:0] gate_reg, gate_next;
	logic sleep_reg, sleep_next;
	logic [2:0] wake_cnt_reg, wake_cnt_next;
	logic bod_off_reg, bod_off_next;
	logic [7:0] rdata_reg, rdata_next;
	logic sel_sleep_mode_control, sel_cpu_control, sel_gate;
	logic wr_sleep_mode_control, wr_cpu_control, wr_gate;
	logic brownout_sleep_off_active;

	// Match either the data address or the short I/O alias
	function automatic logic addr_match(input logic [7:0] a, input logic io, input logic [7:0] reg_addr);
		logic [7:0] io_addr;
		io_addr = reg_addr - PMCR_IO_OFFSET;
		if (io)
		begin
			addr_match = (reg_addr <= PMCR_IO_LIMIT + PMCR_IO_OFFSET) && (a == io_addr); // RULE1
		end
		else
		begin
			addr_match = (a == reg_addr); // RULE1
		end
	endfunction

	always_comb
	begin
		sel_sleep_mode_control = addr_match(addr_i, io_space_i, PMCR_SLEEP_MODE_CONTROL_ADDR);
		sel_cpu_control = addr_match(addr_i, io_space_i, PMCR_CPU_CONTROL_ADDR);
		sel_gate = addr_match(addr_i, io_space_i, PMCR_PERIPHERAL_CLOCK_GATE_ADDR);
		wr_sleep_mode_control = wr_i && sel_sleep_mode_control;
		wr_cpu_control = wr_i && sel_cpu_control;
		wr_gate = wr_i && sel_gate;
		brownout_sleep_off_active = brownout_sleep_off_reg && (brownout_sleep_off_cnt_reg >= PMCR_BROWNOUT_DELAY_CYCLES); // RULE9
	end

	// Register next values
	always_comb
	begin
		sleep_mode_control_next = sleep_mode_control_reg;
		scan_off_next = scan_off_reg;
		scan_pend_next = scan_pend_reg;
		scan_val_next = scan_val_reg;
		scan_cnt_next = scan_cnt_reg;
		brownout_sleep_off_next = brownout_sleep_off_reg;
		brownout_sleep_unlock_next = brownout_sleep_unlock_reg;
		brownout_sleep_unlock_cnt_next = brownout_sleep_unlock_cnt_reg;
		brownout_sleep_off_cnt_next = brownout_sleep_off_cnt_reg;
		pud_next = pud_reg;
		vector_base_select_next = vector_base_select_reg;
		vector_change_unlock_next = vector_change_unlock_reg;
		vector_change_unlock_cnt_next = vector_change_unlock_cnt_reg;
		ivmask_tail_next = 1'b0;
		gate_next = gate_reg;
		if (wr_sleep_mode_control)
		begin
			sleep_mode_control_next = wdata_i[3:0] & PMCR_SLEEP_MODE_CONTROL_MASK[3:0]; // RULE23
		end
		if (wr_gate)
		begin
			gate_next = wdata_i; // RULE16
		end
		// Scan port off timed sequence
		if (scan_pend_reg)
		begin
			scan_cnt_next = scan_cnt_reg + 3'h1;
			if (scan_cnt_reg + 3'h1 >= PMCR_TIMED_WINDOW_CYCLES)
			begin
				scan_pend_next = 1'b0;
			end
		end
		if (wr_cpu_control)
		begin
			if (scan_pend_reg && (wdata_i[PMCR_SCAN_PORT_OFF_BIT] == scan_val_reg))
			begin
				scan_off_next = scan_val_reg; // RULE6
				scan_pend_next = 1'b0;
			end
			else
			begin
				scan_pend_next = 1'b1; // RULE6
				scan_val_next = wdata_i[PMCR_SCAN_PORT_OFF_BIT];
				scan_cnt_next = 3'h0;
			end
			pud_next = wdata_i[PMCR_PULLUP_GLOBAL_OFF_BIT];
		end
		// Brownout sleep off unlock and timing
		if (brownout_sleep_unlock_reg)
		begin
			brownout_sleep_unlock_cnt_next = brownout_sleep_unlock_cnt_reg + 3'h1;
			if (brownout_sleep_unlock_cnt_reg + 3'h1 >= PMCR_TIMED_WINDOW_CYCLES)
			begin
				brownout_sleep_unlock_next = 1'b0;
			end
		end
		if (brownout_sleep_off_reg)
		begin
			brownout_sleep_off_cnt_next = brownout_sleep_off_cnt_reg + 3'h1;
			if (brownout_sleep_off_cnt_reg + 3'h1 >= PMCR_BROWNOUT_DELAY_CYCLES + PMCR_BROWNOUT_ACTIVE_CYCLES)
			begin
				brownout_sleep_off_next = 1'b0; // RULE9
			end
		end
		if (wr_cpu_control && wdata_i[PMCR_BROWNOUT_SLEEP_OFF_BIT])
		begin
			if (wdata_i[PMCR_BROWNOUT_SLEEP_UNLOCK_BIT])
			begin
				brownout_sleep_unlock_next = 1'b1; // RULE8
				brownout_sleep_unlock_cnt_next = 3'h0;
			end
			else if (brownout_sleep_unlock_reg && !brownout_sleep_off_reg)
			begin
				brownout_sleep_off_next = 1'b1; // RULE8
				brownout_sleep_off_cnt_next = 3'h0;
				brownout_sleep_unlock_next = 1'b0;
			end
		end
		// Vector base timed change
		if (vector_change_unlock_reg)
		begin
			vector_change_unlock_cnt_next = vector_change_unlock_cnt_reg + 3'h1;
			if (vector_change_unlock_cnt_reg + 3'h1 >= PMCR_TIMED_WINDOW_CYCLES)
			begin
				vector_change_unlock_next = 1'b0; // RULE13
			end
		end
		if (wr_cpu_control)
		begin
			if (wdata_i[PMCR_VECTOR_CHANGE_UNLOCK_BIT])
			begin
				vector_change_unlock_next = 1'b1; // RULE12
				vector_change_unlock_cnt_next = 3'h0;
			end
			else if (vector_change_unlock_reg)
			begin
				vector_base_select_next = wdata_i[PMCR_VECTOR_BASE_SELECT_BIT]; // RULE12
				vector_change_unlock_next = 1'b0; // RULE13
				ivmask_tail_next = 1'b1; // RULE14
			end
		end
	end

	// Sleep entry and standby wake timing
	// Brownout off sampled at sleep entry, held until wake
	always_comb
	begin
		sleep_next = sleep_reg;
		wake_cnt_next = wake_cnt_reg;
		bod_off_next = bod_off_reg;
		if (!sleep_reg && sleep_instr_i && sleep_mode_control_reg[PMCR_SLEEP_ARM_BIT])
		begin
			sleep_next = 1'b1; // RULE3
			bod_off_next = brownout_sleep_off_active; // RULE9
			wake_cnt_next = 3'h0;
		end
		else if (sleep_reg && (wake_i || wake_cnt_reg != 3'h0))
		begin
			if (sleep_mode_control_reg[PMCR_SLEEP_MODE_HI_BIT:PMCR_SLEEP_MODE_LO_BIT] == PMCR_MODE_STANDBY ||
				sleep_mode_control_reg[PMCR_SLEEP_MODE_HI_BIT:PMCR_SLEEP_MODE_LO_BIT] == PMCR_MODE_EXT_STANDBY)
			begin
				wake_cnt_next = wake_cnt_reg + 3'h1;
				if (wake_cnt_reg + 3'h1 >= PMCR_STANDBY_WAKE_CYCLES)
				begin
					sleep_next = 1'b0; // RULE22
					bod_off_next = 1'b0;
					wake_cnt_next = 3'h0;
				end
			end
			else
			begin
				sleep_next = 1'b0;
				bod_off_next = 1'b0;
			end
		end
	end

	// Read data
	always_comb
	begin
		rdata_next = 8'h00;
		if (rd_i && sel_sleep_mode_control)
		begin
			rdata_next = {4'h0, sleep_mode_control_reg}; // RULE23
		end
		else if (rd_i && sel_cpu_control)
		begin
			rdata_next = {scan_off_reg, brownout_sleep_off_reg, brownout_sleep_unlock_reg, pud_reg, 2'h0, vector_base_select_reg, vector_change_unlock_reg}; // RULE23
		end
		else if (rd_i && sel_gate)
		begin
			rdata_next = gate_reg;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			sleep_mode_control_reg <= PMCR_SLEEP_MODE_CONTROL_RESET[3:0];
			scan_off_reg <= PMCR_CPU_CONTROL_RESET[PMCR_SCAN_PORT_OFF_BIT];
			scan_pend_reg <= 1'b0;
			scan_val_reg <= 1'b0;
			scan_cnt_reg <= 3'h0;
			brownout_sleep_off_reg <= PMCR_CPU_CONTROL_RESET[PMCR_BROWNOUT_SLEEP_OFF_BIT];
			brownout_sleep_unlock_reg <= PMCR_CPU_CONTROL_RESET[PMCR_BROWNOUT_SLEEP_UNLOCK_BIT];
			brownout_sleep_unlock_cnt_reg <= 3'h0;
			brownout_sleep_off_cnt_reg <= 3'h0;
			pud_reg <= PMCR_CPU_CONTROL_RESET[PMCR_PULLUP_GLOBAL_OFF_BIT];
			vector_base_select_reg <= PMCR_CPU_CONTROL_RESET[PMCR_VECTOR_BASE_SELECT_BIT];
			vector_change_unlock_reg <= PMCR_CPU_CONTROL_RESET[PMCR_VECTOR_CHANGE_UNLOCK_BIT];
			vector_change_unlock_cnt_reg <= 3'h0;
			ivmask_tail_reg <= 1'b0;
			gate_reg <= PMCR_PERIPHERAL_CLOCK_GATE_RESET;
			sleep_reg <= 1'b0;
			wake_cnt_reg <= 3'h0;
			bod_off_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end
		else
		begin
			sleep_mode_control_reg <= sleep_mode_control_next;
			scan_off_reg <= scan_off_next;
			scan_pend_reg <= scan_pend_next;
			scan_val_reg <= scan_val_next;
			scan_cnt_reg <= scan_cnt_next;
			brownout_sleep_off_reg <= brownout_sleep_off_next;
			brownout_sleep_unlock_reg <= brownout_sleep_unlock_next;
			brownout_sleep_unlock_cnt_reg <= brownout_sleep_unlock_cnt_next;
			brownout_sleep_off_cnt_reg <= brownout_sleep_off_cnt_next;
			pud_reg <= pud_next;
			vector_base_select_reg <= vector_base_select_next;
			vector_change_unlock_reg <= vector_change_unlock_next;
			vector_change_unlock_cnt_reg <= vector_change_unlock_cnt_next;
			ivmask_tail_reg <= ivmask_tail_next;
			gate_reg <= gate_next;
			sleep_reg <= sleep_next;
			wake_cnt_reg <= wake_cnt_next;
			bod_off_reg <= bod_off_next;
			rdata_reg <= rdata_next;
		end
	end

	// Outputs
	always_comb
	begin
		rdata_o = rdata_reg;
		hit_o = sel_sleep_mode_control || sel_cpu_control || sel_gate;
		sleep_o = sleep_reg; // RULE3
		sleep_mode_o = sleep_mode_control_reg[PMCR_SLEEP_MODE_HI_BIT:PMCR_SLEEP_MODE_LO_BIT]; // RULE2
		wake_ready_o = !sleep_reg;
		brownout_off_o = bod_off_reg; // RULE9
		scan_port_enable_o = scan_port_fuse_i && !scan_off_reg; // RULE5
		pullup_global_off_o = pud_reg; // RULE10
		vector_base_select_o = vector_base_select_reg; // RULE11
		irq_block_o = vector_change_unlock_reg || ivmask_tail_reg || // RULE14
			(vector_base_select_reg && app_lock_bit_i && !exec_in_boot_i) || // RULE15
			(!vector_base_select_reg && boot_lock_bit_i && exec_in_boot_i); // RULE15
		gate_clock_o = gate_reg[GATE_COUNT-1:0]; // RULE16 RULE18
		gate_clock_o[PMCR_GATE_TIMER_TWO_BIT] = gate_reg[PMCR_GATE_TIMER_TWO_BIT] && !timer_two_async_select_i; // RULE17
		periph_access_ok_o = ~gate_clock_o; // RULE21
		comparator_mux_allow_o = !gate_reg[PMCR_GATE_CONVERTER_BIT]; // RULE19
	end
endmodule
`default_nettype wire

/* File: pmcr_props.sv */
// Checker for the power control register block
`timescale 1ns/1ps
`default_nettype none
module pmcr_props
	import pmcr_pkg::*;
#(
	parameter int GATE_COUNT = 8
)
(
	// Clock, reset and access
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] addr_i,
	input wire logic io_space_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] rdata_o,
	input wire logic hit_o,
	// Sleep and controls
	input wire logic sleep_instr_i,
	input wire logic wake_i,
	input wire logic sleep_o,
	input wire logic [2:0] sleep_mode_o,
	input wire logic brownout_off_o,
	input wire logic scan_port_fuse_i,
	input wire logic scan_port_enable_o,
	input wire logic pullup_global_off_o,
	input wire logic vector_base_select_o,
	input wire logic irq_block_o,
	input wire logic [GATE_COUNT-1:0] gate_clock_o,
	input wire logic [GATE_COUNT-1:0] periph_access_ok_o,
	input wire logic timer_two_async_select_i
);
	logic cpu_wr;
	assign cpu_wr = wr_i && ((!io_space_i && addr_i == 8'h55) || (io_space_i && addr_i == 8'h35));
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	hit_decode_a: assert property (
		hit_o == ((!io_space_i && (addr_i == 8'h53 || addr_i == 8'h55 || addr_i == 8'h64))
		|| (io_space_i && (addr_i == 8'h33 || addr_i == 8'h35)))) else $error("decode wrong");
	read_idle_a: assert property (!rd_i |=> rdata_o == 8'h00) else $error("idle read data");
	sleep_cause_a: assert property ($rose(sleep_o) |-> $past(sleep_instr_i)) else $error("sleep cause");
	standby_wake_a: assert property (
		sleep_o && wake_i && sleep_mode_o[2:1] == 2'b11 |=> sleep_o [*5] ##1 !sleep_o) else $error("standby wake");
	quick_wake_a: assert property (
		sleep_o && wake_i && sleep_mode_o[2:1] != 2'b11 |=> !sleep_o) else $error("fast wake");
	bod_sleep_a: assert property (brownout_off_o |-> sleep_o) else $error("brownout off awake");
	scan_fuse_a: assert property (scan_port_enable_o |-> scan_port_fuse_i) else $error("scan enable");
	access_ok_a: assert property (periph_access_ok_o == ~gate_clock_o) else $error("access ok");
	irq_unlock_a: assert property (cpu_wr && wdata_i[0] |=> irq_block_o) else $error("irq not masked");
	pullup_wr_a: assert property (
		cpu_wr |=> pullup_global_off_o == $past(wdata_i[4])) else $error("pull-up bit");
	vec_change_a: assert property ($changed(vector_base_select_o) |-> $past(cpu_wr)) else $error("vector");
	bod_hold_a: assert property (
		sleep_o && $past(sleep_o) |-> $stable(brownout_off_o)) else $error("brownout off changed in sleep");
	gate_async_a: assert property (
		timer_two_async_select_i |-> !gate_clock_o[PMCR_GATE_TIMER_TWO_BIT]) else $error("timer two gated");
	cover property (cpu_wr && wdata_i[0]);
	cover property ($fell(sleep_o));
	cover property (brownout_off_o);
endmodule
bind pmcr_power_control pmcr_props #(.GATE_COUNT(GATE_COUNT)) u_props
(
	.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .io_space_i(io_space_i),
	.wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .hit_o(hit_o),
	.sleep_instr_i(sleep_instr_i), .wake_i(wake_i), .sleep_o(sleep_o), .sleep_mode_o(sleep_mode_o),
	.brownout_off_o(brownout_off_o), .scan_port_fuse_i(scan_port_fuse_i),
	.scan_port_enable_o(scan_port_enable_o), .pullup_global_off_o(pullup_global_off_o),
	.vector_base_select_o(vector_base_select_o), .irq_block_o(irq_block_o),
	.gate_clock_o(gate_clock_o), .periph_access_ok_o(periph_access_ok_o),
	.timer_two_async_select_i(timer_two_async_select_i)
);
`default_nettype wire

/* File: tb.sv */
// Testbench for the power control register block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pmcr_pkg::*;
	logic clk_i = 0, reset_n_i = 0, io_space_i = 0, wr_i = 0, rd_i = 0, sleep_instr_i = 0, wake_i = 0;
	logic scan_port_fuse_i = 1, app_lock_bit_i = 0, boot_lock_bit_i = 0, exec_in_boot_i = 0;
	logic timer_two_async_select_i = 0;
	logic [7:0] addr_i = 0, wdata_i = 0, rdata_o, gate_clock_o, periph_access_ok_o;
	logic hit_o, sleep_o, wake_ready_o, brownout_off_o, scan_port_enable_o, pullup_global_off_o;
	logic vector_base_select_o, irq_block_o, comparator_mux_allow_o;
	logic [2:0] sleep_mode_o;
	logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
	int n_fail = 0, check_count = 0, n;
	always #50 clk_i = ~clk_i;
	pmcr_power_control DUT
	(
		.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .io_space_i(io_space_i),
		.wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .hit_o(hit_o),
		.sleep_instr_i(sleep_instr_i), .wake_i(wake_i), .sleep_o(sleep_o), .sleep_mode_o(sleep_mode_o),
		.wake_ready_o(wake_ready_o), .brownout_off_o(brownout_off_o),
		.scan_port_fuse_i(scan_port_fuse_i), .app_lock_bit_i(app_lock_bit_i),
		.boot_lock_bit_i(boot_lock_bit_i), .exec_in_boot_i(exec_in_boot_i),
		.timer_two_async_select_i(timer_two_async_select_i),
		.scan_port_enable_o(scan_port_enable_o), .pullup_global_off_o(pullup_global_off_o),
		.vector_base_select_o(vector_base_select_o), .irq_block_o(irq_block_o),
		.gate_clock_o(gate_clock_o), .periph_access_ok_o(periph_access_ok_o),
		.comparator_mux_allow_o(comparator_mux_allow_o)
	);
	task chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic io, input logic [7:0] d);
		@(negedge clk_i);
		addr_i = a;
		io_space_i = io;
		wdata_i = d;
		wr_i = 1;
		@(negedge clk_i);
		wr_i = 0;
	endtask
	task rd(input logic [7:0] a, input logic io, input logic [7:0] exp);
		@(negedge clk_i);
		addr_i = a;
		io_space_i = io;
		rd_i = 1;
		@(negedge clk_i);
		rd_i = 0;
		chk(rdata_o, exp);
	endtask
	task pulse;
		@(negedge clk_i);
		sleep_instr_i = 1;
		@(negedge clk_i);
		sleep_instr_i = 0;
	endtask
	task slp(input logic [2:0] m);
		wr(8'h53, 0, {4'h0, m, 1'b1});
		pulse();
		chk(sleep_o, 1);
		chk(wake_ready_o, 0);
		chk(sleep_mode_o, m);
		wake_i = 1;
		n = 0;
		do
		begin
			@(negedge clk_i);
			wake_i = 0;
			n++;
		end
		while (sleep_o && n < 10);
		chk(8'(n), (m[2:1] == 2'b11) ? 8'(PMCR_STANDBY_WAKE_CYCLES) : 8'h01);
		if (sleep_o)
			stop_test();
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(negedge clk_i);
		reset_n_i = 1;
		rd(8'h53, 0, 8'h00);
		rd(8'h55, 0, 8'h00);
		rd(8'h64, 0, 8'h00);
		chk(scan_port_enable_o, 1);
		scan_port_fuse_i = 0;
		@(negedge clk_i);
		chk(scan_port_enable_o, 0);
		scan_port_fuse_i = 1;
		$display("test reset done");
		wr(8'h33, 1, 8'hff);
		rd(8'h53, 0, 8'h0f);
		rd(8'h33, 1, 8'h0f);
		chk(hit_o, 1);
		wr(8'h44, 1, 8'hff);
		chk(hit_o, 0);
		rd(8'h64, 0, 8'h00);
		rd(8'h60, 0, 8'h00);
		chk(hit_o, 0);
		$display("test decode done");
		wr(8'h53, 0, 8'h04);
		pulse();
		chk(sleep_o, 0);
		for (int i = 0; i < 6; i++)
			slp(modes[i]);
		wr(8'h53, 0, 8'h00);
		$display("test sleep done");
		wr(8'h55, 0, 8'h80);
		repeat (5) @(negedge clk_i);
		rd(8'h55, 0, 8'h00);
		wr(8'h55, 0, 8'h80);
		wr(8'h55, 0, 8'h80);
		rd(8'h55, 0, 8'h80);
		chk(scan_port_enable_o, 0);
		wr(8'h55, 0, 8'h00);
		wr(8'h55, 0, 8'h00);
		chk(scan_port_enable_o, 1);
		$display("test scan port done");
		repeat (5) @(negedge clk_i);
		wr(8'h55, 0, 8'h40);
		rd(8'h55, 0, 8'h00);
		wr(8'h53, 0, 8'h05);
		wr(8'h55, 0, 8'h60);
		wr(8'h55, 0, 8'h40);
		pulse();
		chk(brownout_off_o, 0);
		wake_i = 1;
		@(negedge clk_i);
		wake_i = 0;
		repeat (5) @(negedge clk_i);
		wr(8'h55, 0, 8'h60);
		wr(8'h55, 0, 8'h40);
		repeat (2) @(negedge clk_i);
		pulse();
		n = 0;
		repeat (8)
		begin
			n += brownout_off_o;
			@(negedge clk_i);
		end
		chk(8'(n), 8'h08);
		wake_i = 1;
		@(negedge clk_i);
		wake_i = 0;
		rd(8'h55, 0, 8'h00);
		wr(8'h53, 0, 8'h00);
		$display("test brownout done");
		wr(8'h55, 0, 8'h01);
		chk(irq_block_o, 1);
		wr(8'h55, 0, 8'h02);
		chk(irq_block_o, 1);
		chk(vector_base_select_o, 1);
		@(negedge clk_i);
		chk(irq_block_o, 0);
		rd(8'h55, 0, 8'h02);
		wr(8'h55, 0, 8'h01);
		repeat (5) @(negedge clk_i);
		chk(irq_block_o, 0);
		wr(8'h55, 0, 8'h00);
		rd(8'h55, 0, 8'h02);
		app_lock_bit_i = 1;
		@(negedge clk_i);
		chk(irq_block_o, 1);
		exec_in_boot_i = 1;
		@(negedge clk_i);
		chk(irq_block_o, 0);
		app_lock_bit_i = 0;
		$display("test vector done");
		wr(8'h55, 0, 8'h12);
		chk(pullup_global_off_o, 1);
		wr(8'h64, 0, 8'hff);
		rd(8'h64, 0, 8'hff);
		timer_two_async_select_i = 1;
		@(negedge clk_i);
		chk(gate_clock_o, 8'hbf);
		chk(periph_access_ok_o, 8'h40);
		chk(comparator_mux_allow_o, 0);
		wr(8'h64, 0, 8'h5a);
		chk(gate_clock_o, 8'h1a);
		timer_two_async_select_i = 0;
		@(negedge clk_i);
		chk(gate_clock_o, 8'h5a);
		chk(comparator_mux_allow_o, 1);
		wr(8'h64, 0, 8'h00);
		chk(gate_clock_o, 8'h00);
		chk(periph_access_ok_o, 8'hff);
		$display("test gates done");
		stop_test();
	end
endmodule
`default_nettype wire
